/* pofs_defs.svh */
// Purpose: constants for the pwm output fault stage
// Assumes: included by bare name from the package and the design files
// Notes: channel and fault counts, widths, mode codes, reset values and the filter counter limit
`ifndef POFS_DEFS_SVH
`define POFS_DEFS_SVH

`define POFS_NUM_CHAN      8
`define POFS_NUM_PAIR      4
`define POFS_NUM_FAULT     4
`define POFS_NUM_TRIG      6
`define POFS_CNT_W         16
`define POFS_FAULT_FILTER_VALUE_W       4
`define POFS_FCNT_W        5
`define POFS_FMODE_OFF     2'h0
`define POFS_FMODE_AUTO    2'h3
`define POFS_MASK_RST      8'h00
`define POFS_FCNT_MAX      5'h1f

`endif

/* pofs_pkg.sv */
// Purpose: shared types of the pwm output fault stage
// Assumes: pofs_defs.svh holds the numeric constants
// Notes: packed structs carry grouped controls
`include "pofs_defs.svh"
package pofs_pkg;

  // per-fault-input configuration
  typedef struct packed {
    logic [`POFS_NUM_FAULT-1:0] input_enable;
    logic [`POFS_NUM_FAULT-1:0] filter_enable;
    logic [`POFS_NUM_FAULT-1:0] polarity;
    logic [`POFS_FAULT_FILTER_VALUE_W-1:0]   filter_value;
    logic [1:0]                 mode;
  } pofs_fault_cfg_t;

  // per-channel output configuration
  typedef struct packed {
    logic [`POFS_NUM_CHAN-1:0] active_level;
    logic [`POFS_NUM_CHAN-1:0] preset_value;
    logic [`POFS_NUM_PAIR-1:0] fault_pair_enable;
    logic [`POFS_NUM_PAIR-1:0] paired_inverse_mode;
    logic [`POFS_NUM_PAIR-1:0] deadtime_enable;
  } pofs_chan_cfg_t;

  // counter events from the timer core
  typedef struct packed {
    logic                   natural_wrap;
    logic                   counter_write;
    logic                   counter_sync;
    logic                   clock_start;
    logic                   capture_reset;
    logic [`POFS_CNT_W-1:0] counter_value;
    logic [`POFS_CNT_W-1:0] counter_initial_value;
  } pofs_cnt_evt_t;

  typedef enum logic [1:0] {
    POFS_RUN,
    POFS_FAULTED,
    POFS_WAIT_CYCLE
  } pofs_fstate_t;

endpackage

/* pofs_fault_filter.sv */
// Purpose: synchroniser, glitch filter and edge detect for one fault input
// Assumes: fault pin asynchronous to clk_i
// Notes: flag set is handled by the caller from rise_o
`timescale 1ns/1ns
`include "pofs_defs.svh"
module pofs_fault_filter (
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     pin_i,
  input  wire logic                     polarity_i,
  input  wire logic                     bypass_i,
  input  wire logic [`POFS_FAULT_FILTER_VALUE_W-1:0] filter_value_i,
  output logic                          level_o,
  output logic                          rise_o
);
  logic                    sync_a;
  logic                    sync_b;
  logic                    filt;
  logic                    prev;
  logic [`POFS_FCNT_W-1:0] cnt;
  wire                     fault_lvl = sync_b ^ polarity_i;
  wire                     validate  = cnt >= {1'b0, filter_value_i};
  wire                     chosen    = bypass_i ? fault_lvl : filt;

  // two-flop synchroniser, first flop read by the second only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= pin_i;
      sync_b <= sync_a;
    end
  end

  // counter runs while the level differs from the filtered one, any return clears it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt  <= 5'h00;
      filt <= 1'b0;
    end else if (bypass_i) begin
      cnt  <= 5'h00; // filt tracks so enabling the filter makes no false edge
      filt <= fault_lvl;
    end else if (fault_lvl == filt) begin
      cnt <= 5'h00;
    end else if (validate) begin
      filt <= fault_lvl;
      cnt  <= 5'h00;
    end else if (cnt != `POFS_FCNT_MAX) begin
      cnt <= cnt + 5'h01;
    end
  end

  // edge detector on the chosen path
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev <= 1'b0;
    end else begin
      prev <= chosen;
    end
  end

  assign level_o = chosen;
  assign rise_o  = chosen & ~prev;
endmodule

/* pofs_output_stage.sv */
// Purpose: output mask, fault safe state, polarity, preset forcing, triggers
// Assumes: pwm_i is active-high from the upstream combine/deadtime logic
// Notes: all on clk_i; fault pins pass two flops first
// Functional notes
// - mask writes buffered, loaded on sync
// - masked channel driven to inactive level
// - fault_mode zero disables fault control
// - four fault inputs, shared filter value
// - synchronised, 5-bit counter validates stable level
// - short pulses dropped, counter cleared
// - bypassed filter: flag on third edge
// - filtered: flag four plus value edges later
// - rising edge sets flag; any is OR
// - fault forces pair to inactive levels
// - irq while any flag and enable
// - auto recovery: input low plus cycle start
// - manual recovery: flags cleared plus cycle start
// - fault polarity selects active fault level
// - active level zero means active high
// - preset forcing drives preset values
// - complementary pairs: n+1 gets complement
// - channel match triggers for channels 0-5
// - initialization trigger on counter reload
`timescale 1ns/1ns
`include "pofs_defs.svh"
module pofs_output_stage (
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  input  wire logic [`POFS_NUM_CHAN-1:0]   pwm_i,
  input  wire logic [`POFS_NUM_CHAN-1:0]   mask_wdata_i,
  input  wire logic                        mask_write_i,
  input  wire logic                        pwm_sync_i,
  input  wire logic                        cycle_start_i,
  input  wire logic [`POFS_NUM_FAULT-1:0]  fault_pin_i,
  input  wire pofs_pkg::pofs_fault_cfg_t   fault_cfg_i,
  input  wire pofs_pkg::pofs_chan_cfg_t    chan_cfg_i,
  input  wire logic                        fault_irq_enable_i,
  input  wire logic [`POFS_NUM_FAULT-1:0]  flag_clear_i,
  input  wire logic                        force_preset_i,
  input  wire logic [`POFS_NUM_TRIG-1:0]   chan_trigger_enable_i,
  input  wire logic [`POFS_NUM_TRIG*`POFS_CNT_W-1:0] chan_compare_value_i,
  input  wire logic                        preset_trigger_enable_i,
  input  wire pofs_pkg::pofs_cnt_evt_t     cnt_evt_i,
  output logic [`POFS_NUM_CHAN-1:0]        chan_out_o,
  output logic [`POFS_NUM_CHAN-1:0]        output_mask_reg_o,
  output logic [`POFS_NUM_FAULT-1:0]       fault_input_flag_o,
  output logic                             fault_flag_any_o,
  output logic                             fault_input_level_o,
  output logic                             fault_irq_o,
  output logic [`POFS_NUM_TRIG-1:0]        chan_trig_o,
  output logic                             init_trig_o
);
  import pofs_pkg::*;

  logic [`POFS_NUM_CHAN-1:0]  mask_buf;
  logic [`POFS_NUM_CHAN-1:0]  mask_act;
  logic [`POFS_NUM_FAULT-1:0] flag;
  logic [`POFS_NUM_FAULT-1:0] lvl;
  logic [`POFS_NUM_FAULT-1:0] rise;
  logic [`POFS_NUM_CHAN-1:0]  chan_q;
  logic [`POFS_NUM_TRIG-1:0]  ctrig_q;
  logic                       itrig_q;
  logic                       forcing;
  logic [`POFS_NUM_CHAN-1:0]  preset_q;
  pofs_fstate_t               fstate;
  pofs_fstate_t               next_fstate;

  wire fault_on   = fault_cfg_i.mode != `POFS_FMODE_OFF;
  wire auto_mode  = fault_cfg_i.mode == `POFS_FMODE_AUTO;
  wire any_flag   = |flag;
  wire any_level  = |(lvl & fault_cfg_i.input_enable);
  wire [`POFS_NUM_FAULT-1:0] bypass =
    ~fault_cfg_i.filter_enable | ~fault_cfg_i.input_enable |
    {`POFS_NUM_FAULT{fault_cfg_i.filter_value == 4'h0}};
  wire [`POFS_NUM_FAULT-1:0] set_flag =
    rise & fault_cfg_i.input_enable & {`POFS_NUM_FAULT{fault_on}};

  // one filter per fault input
  genvar g;
  generate
    for (g = 0; g < `POFS_NUM_FAULT; g = g + 1) begin : g_flt
      pofs_fault_filter u_flt (
        .clk_i          (clk_i),
        .rst_b_i        (rst_b_i),
        .pin_i          (fault_pin_i[g]),
        .polarity_i     (fault_cfg_i.polarity[g]),
        .bypass_i       (bypass[g]),
        .filter_value_i (fault_cfg_i.filter_value),
        .level_o        (lvl[g]),
        .rise_o         (rise[g])
      );
    end
  endgenerate

  // sticky flags, a new fault beats a clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag <= 4'h0;
    end else begin
      flag <= (flag & ~flag_clear_i) | set_flag;
    end
  end

  // mask buffer and active copy, active updates only at sync
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_buf <= `POFS_MASK_RST;
      mask_act <= `POFS_MASK_RST;
    end else begin
      if (mask_write_i) begin
        mask_buf <= mask_wdata_i;
      end
      if (pwm_sync_i) begin
        mask_act <= mask_buf;
      end
    end
  end

  // fault safe-state sequencer; outputs return at a cycle start, or at once when fault mode is off
  always_comb begin
    next_fstate = fstate;
    case (fstate)
      POFS_RUN: begin
        if (fault_on && |set_flag) begin
          next_fstate = POFS_FAULTED;
        end
      end
      POFS_FAULTED: begin
        if (!fault_on) begin
          next_fstate = POFS_RUN;
        end else if (auto_mode ? !any_level : !any_flag) begin
          next_fstate = POFS_WAIT_CYCLE;
        end
      end
      POFS_WAIT_CYCLE: begin
        if (!fault_on) begin
          next_fstate = POFS_RUN;
        end else if (auto_mode ? any_level : any_flag) begin
          next_fstate = POFS_FAULTED;
        end else if (cycle_start_i) begin
          next_fstate = POFS_RUN;
        end
      end
      default: next_fstate = POFS_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fstate <= POFS_RUN;
    end else begin
      fstate <= next_fstate;
    end
  end

  wire faulted = fstate != POFS_RUN;

  // forcing is latched on the command and held until the next cycle start
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      forcing  <= 1'b0;
      preset_q <= 8'h00;
    end else if (force_preset_i) begin
      forcing  <= 1'b1;
      preset_q <= chan_cfg_i.preset_value;
    end else if (cycle_start_i) begin
      forcing  <= 1'b0;
    end
  end

  // per-pair output composition; priority: preset, fault, mask, polarity
  logic [`POFS_NUM_CHAN-1:0] next_chan;
  generate
    for (g = 0; g < `POFS_NUM_PAIR; g = g + 1) begin : g_pair
      wire cmp  = chan_cfg_i.paired_inverse_mode[g] | chan_cfg_i.deadtime_enable[g];
      wire pn   = preset_q[2*g];
      wire pn1  = cmp ? ~preset_q[2*g] : preset_q[2*g+1];
      wire ffrc = faulted & chan_cfg_i.fault_pair_enable[g];
      wire [1:0] pwm = pwm_i[2*g+1:2*g] & ~mask_act[2*g+1:2*g];
      wire [1:0] pol = chan_cfg_i.active_level[2*g+1:2*g];
      assign next_chan[2*g+1:2*g] = forcing ? {pn1, pn} :
                                    ffrc    ? pol :
                                    pwm ^ pol;
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chan_q <= 8'h00;
    end else begin
      chan_q <= next_chan;
    end
  end

  // match triggers, one cycle each since a match only counts in a cycle where the counter value moved
  logic [`POFS_NUM_TRIG-1:0] match;
  generate
    for (g = 0; g < `POFS_NUM_TRIG; g = g + 1) begin : g_trig
      assign match[g] = chan_trigger_enable_i[g] &&
        cnt_evt_i.counter_value == chan_compare_value_i[g*`POFS_CNT_W +: `POFS_CNT_W];
    end
  endgenerate

  logic [`POFS_CNT_W-1:0] last_cnt;
  wire cnt_moved = last_cnt != cnt_evt_i.counter_value;
  // a clock start reloads only when the counter already sits at its initial value
  wire start_eq = cnt_evt_i.clock_start &&
                  cnt_evt_i.counter_value == cnt_evt_i.counter_initial_value;
  wire reload = cnt_evt_i.natural_wrap | cnt_evt_i.counter_write | cnt_evt_i.counter_sync |
                start_eq | cnt_evt_i.capture_reset;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrig_q  <= 6'h00;
      itrig_q  <= 1'b0;
      last_cnt <= 16'h0000;
    end else begin
      last_cnt <= cnt_evt_i.counter_value;
      ctrig_q  <= match & {`POFS_NUM_TRIG{cnt_moved}};
      itrig_q  <= preset_trigger_enable_i & reload;
    end
  end

  assign chan_out_o          = chan_q;
  assign output_mask_reg_o   = mask_act;
  assign fault_input_flag_o  = flag;
  assign fault_flag_any_o    = any_flag;
  assign fault_input_level_o = any_level;
  assign fault_irq_o         = any_flag & fault_irq_enable_i;
  assign chan_trig_o         = ctrig_q;
  assign init_trig_o         = itrig_q;

  // assertions
  property p_mask_load;
    @(posedge clk_i) disable iff (!rst_b_i)
      pwm_sync_i |=> output_mask_reg_o == $past(mask_buf);
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask not loaded");

  property p_mask_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      !pwm_sync_i |=> $stable(output_mask_reg_o);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed");

  property p_irq;
    @(posedge clk_i) disable iff (!rst_b_i)
      fault_irq_o && fault_irq_enable_i && !(|flag_clear_i)
        |=> fault_irq_o || !fault_irq_enable_i;
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_flag_set;
    @(posedge clk_i) disable iff (!rst_b_i)
      |set_flag |=> fault_flag_any_o;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag lost");

  property p_off;
    @(posedge clk_i) disable iff (!rst_b_i)
      !fault_on |=> (fault_input_flag_o & ~$past(fault_input_flag_o)) == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("fault while off");

  sequence s_fault_seen;
    fault_on && |set_flag && fstate == POFS_RUN;
  endsequence
  property p_fault_safe;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_fault_seen ##1 (faulted && !forcing && chan_cfg_i.fault_pair_enable[1])
        |=> chan_out_o[3:2] == $past(chan_cfg_i.active_level[3:2]);
  endproperty
  a_fault_safe: assert property (p_fault_safe) else $error("no safe state");

  property p_resume;
    @(posedge clk_i) disable iff (!rst_b_i)
      fstate == POFS_WAIT_CYCLE && !cycle_start_i |=> fstate != POFS_RUN;
  endproperty
  a_resume: assert property (p_resume) else $error("early resume");

  property p_preset;
    @(posedge clk_i) disable iff (!rst_b_i)
      force_preset_i && !chan_cfg_i.paired_inverse_mode[0] && !chan_cfg_i.deadtime_enable[0]
        ##1 forcing |=> chan_out_o[1:0] == $past(preset_q[1:0], 1);
  endproperty
  a_preset: assert property (p_preset) else $error("preset wrong");

  property p_itrig;
    @(posedge clk_i) disable iff (!rst_b_i)
      preset_trigger_enable_i && reload |=> init_trig_o;
  endproperty
  a_itrig: assert property (p_itrig) else $error("init trigger missing");

  property p_ctrig_pulse;
    @(posedge clk_i) disable iff (!rst_b_i)
      chan_trig_o[0] |=> !chan_trig_o[0];
  endproperty
  a_ctrig_pulse: assert property (p_ctrig_pulse) else $error("trigger stuck");

  // output composition, sampled one edge after its cause
  property p_masked;
    @(posedge clk_i) disable iff (!rst_b_i)
      !forcing && !faulted && mask_act[2]
        |=> chan_out_o[2] == $past(chan_cfg_i.active_level[2]);
  endproperty
  a_masked: assert property (p_masked) else $error("masked level wrong");

  property p_polarity;
    @(posedge clk_i) disable iff (!rst_b_i)
      !forcing && !faulted && !mask_act[0]
        |=> chan_out_o[0] == ($past(pwm_i[0]) ^ $past(chan_cfg_i.active_level[0]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity wrong");

  property p_comp_preset;
    @(posedge clk_i) disable iff (!rst_b_i)
      forcing && (chan_cfg_i.paired_inverse_mode[1] || chan_cfg_i.deadtime_enable[1])
        |=> chan_out_o[3] != chan_out_o[2];
  endproperty
  a_comp_preset: assert property (p_comp_preset) else $error("pair not complementary");

  property p_flag_sticky;
    @(posedge clk_i) disable iff (!rst_b_i)
      fault_input_flag_o[0] && !flag_clear_i[0] |=> fault_input_flag_o[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

  property p_ctrig_match;
    @(posedge clk_i) disable iff (!rst_b_i)
      chan_trigger_enable_i[0] && cnt_moved &&
        cnt_evt_i.counter_value == chan_compare_value_i[`POFS_CNT_W-1:0] |=> chan_trig_o[0];
  endproperty
  a_ctrig_match: assert property (p_ctrig_match) else $error("match trigger missing");

  // recovery may not start while its condition is unmet
  property p_auto_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      fstate == POFS_FAULTED && auto_mode && fault_input_level_o |=> fstate == POFS_FAULTED;
  endproperty
  a_auto_hold: assert property (p_auto_hold) else $error("auto recovery early");

  property p_manual_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      fstate == POFS_FAULTED && fault_on && !auto_mode && fault_flag_any_o
        |=> fstate == POFS_FAULTED;
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("manual recovery early");

  property p_off_release;
    @(posedge clk_i) disable iff (!rst_b_i)
      !fault_on |=> fstate == POFS_RUN;
  endproperty
  a_off_release: assert property (p_off_release) else $error("safe state while off");
endmodule

/* pofs_far_side.sv */
// Purpose: far side model, fault pins and trigger consumer
// Assumes: the bench calls set_pin just after a falling edge
// Notes: counts every trigger pulse that on-chip users would see
`timescale 1ns/1ns
module pofs_far_side (
  input  wire logic       clk_i,
  input  wire logic [5:0] chan_trig_i,
  input  wire logic       init_trig_i,
  output logic      [3:0] fault_pin_o,
  output logic      [7:0] trig_cnt_o
);
  initial begin
    fault_pin_o = 4'h0;
    trig_cnt_o = 8'h00;
  end
  // one count per pulse per cycle, so a stretched pulse shows up
  always @(posedge clk_i) begin
    trig_cnt_o <= trig_cnt_o + 8'(init_trig_i) + 8'($countones(chan_trig_i));
  end
  // pins are plain driven levels, no pull, so no release value
  task automatic set_pin(input int idx, input logic lvl);
    fault_pin_o[idx] = lvl;
  endtask
endmodule

/* tb_top.sv */
// Purpose: self-checking bench of the pwm output fault stage
// Assumes: inputs change on the falling edge, outputs one edge later
// Notes: each scenario task drives and judges on its own
`timescale 1ns/1ns
module tb_top;
  import pofs_pkg::*;
  logic            clk_i = 1'b0;
  logic            rst_b_i = 1'b0;
  logic [7:0]      pwm, mwd, chan_out, out_mask, trig_cnt;
  logic            mwr, sync, cs, irqe, fp, pte, any, flt_lvl, irq, itrig;
  logic [3:0]      pins, clr, flags;
  logic [5:0]      ten, trig;
  logic [95:0]     cmpv;
  pofs_fault_cfg_t fc;
  pofs_chan_cfg_t  cc;
  pofs_cnt_evt_t   ce;
  int              mismatches = 0;
  int              cmp_count = 0;

  always #5 clk_i = ~clk_i;

  pofs_output_stage uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .pwm_i(pwm), .mask_wdata_i(mwd),
    .mask_write_i(mwr), .pwm_sync_i(sync), .cycle_start_i(cs),
    .fault_pin_i(pins), .fault_cfg_i(fc), .chan_cfg_i(cc),
    .fault_irq_enable_i(irqe), .flag_clear_i(clr), .force_preset_i(fp),
    .chan_trigger_enable_i(ten), .chan_compare_value_i(cmpv),
    .preset_trigger_enable_i(pte), .cnt_evt_i(ce), .chan_out_o(chan_out),
    .output_mask_reg_o(out_mask), .fault_input_flag_o(flags),
    .fault_flag_any_o(any), .fault_input_level_o(flt_lvl),
    .fault_irq_o(irq), .chan_trig_o(trig), .init_trig_o(itrig));

  pofs_far_side fs (
    .clk_i(clk_i), .chan_trig_i(trig), .init_trig_i(itrig),
    .fault_pin_o(pins), .trig_cnt_o(trig_cnt));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic cstart();
    cs = 1'b1;
    cyc(1);
    cs = 1'b0;
    cyc(2);
  endtask

  task automatic clear_flags();
    clr = 4'hf;
    cyc(1);
    clr = 4'h0;
    cyc(1);
  endtask

  // expected outputs: forced bits go to their inactive level
  function automatic logic [7:0] ev(input logic [7:0] f);
    return (pwm ^ cc.active_level) & ~f | cc.active_level & f;
  endfunction

  task automatic t_mask();
    cc.active_level = 8'h0f;
    mwd = 8'h3c;
    mwr = 1'b1;
    cyc(1);
    mwr = 1'b0;
    cyc(2);
    check("mask before sync", out_mask, 8'h00);
    check("polarity", chan_out, 8'ha5);
    sync = 1'b1;
    cyc(1);
    sync = 1'b0;
    cyc(1);
    check("mask after sync", out_mask, 8'h3c);
    check("masked out", chan_out, ev(8'h3c));
    mwd = 8'h00;
    mwr = 1'b1;
    cyc(1);
    mwr = 1'b0;
    sync = 1'b1;
    cyc(1);
    sync = 1'b0;
    cyc(2);
  endtask

  task automatic t_bypass();
    fc.input_enable = 4'h7;
    irqe = 1'b1;
    fs.set_pin(0, 1'b1);
    cyc(5);
    check("mode off", flags, 4'h0);
    fs.set_pin(0, 1'b0);
    cyc(4);
    fc.mode = 2'h1;
    fs.set_pin(3, 1'b1);
    cyc(5);
    check("input disabled", flags, 4'h0);
    fs.set_pin(0, 1'b1);
    cyc(2);
    check("flag early", flags, 4'h0);
    cyc(1);
    check("flag third edge", {irq, any, flags}, 6'h31);
    irqe = 1'b0;
    cyc(1);
    check("irq disabled", irq, 1'b0);
    // polarity acts at once but the pin lags two flops, so flip both with input 1 off
    fc.input_enable = 4'h5;
    fc.polarity = 4'h2;
    fs.set_pin(1, 1'b1);
    cyc(4);
    fc.input_enable = 4'h7;
    cyc(2);
    check("high no fault", flags, 4'h1);
    fs.set_pin(1, 1'b0);
    cyc(3);
    check("low fault", flags, 4'h3);
    fs.set_pin(0, 1'b0);
    fs.set_pin(1, 1'b1);
    fs.set_pin(3, 1'b0);
    cyc(4);
    clear_flags();
    check("flags cleared", {any, flags}, 5'h00);
  endtask

  task automatic t_filter();
    fc.filter_enable = 4'h4;
    fc.filter_value = 4'h3;
    fs.set_pin(2, 1'b1);
    cyc(2);
    fs.set_pin(2, 1'b0);
    cyc(12);
    check("glitch", flags, 4'h0);
    fs.set_pin(2, 1'b1);
    cyc(6);
    check("filtered early", flags, 4'h0);
    cyc(1);
    check("filtered flag", flags, 4'h4);
    fs.set_pin(2, 1'b0);
    cyc(12);
    clear_flags();
    fc.filter_enable = 4'h0;
    // back to run so the recovery scenarios start unfaulted
    cstart();
  endtask

  task automatic t_recover(input logic [1:0] md);
    logic [7:0] hold;
    hold = (md == 2'h3) ? 8'h00 : 8'h0c;
    fc.mode = md;
    cc.fault_pair_enable = 4'h2;
    fs.set_pin(0, 1'b1);
    cyc(4);
    check("safe state", chan_out, ev(8'h0c));
    check("fault level", flt_lvl, 1'b1);
    fs.set_pin(0, 1'b0);
    cyc(4);
    cstart();
    check("after level low", chan_out, ev(hold));
    clear_flags();
    cyc(1);
    check("cleared no cycle", chan_out, ev(hold));
    cstart();
    check("resumed", chan_out, ev(8'h00));
  endtask

  task automatic t_preset();
    cc.preset_value = 8'hb4;
    cc.paired_inverse_mode = 4'h2;
    cc.deadtime_enable = 4'h4;
    // counter held still, no invert or software control here
    fp = 1'b1;
    cyc(1);
    fp = 1'b0;
    cyc(3);
    // pairs 1 and 2 complementary, pairs 0 and 3 independent
    check("preset", chan_out, 8'h94);
    cstart();
    check("preset end", chan_out, ev(8'h00));
  endtask

  task automatic t_trig();
    int j;
    logic [7:0] n0;
    n0 = trig_cnt;
    ten = 6'h2b;
    for (j = 0; j < 6; j++) cmpv[16*j +: 16] = 16'h0040 + 16'(j);
    for (j = 0; j < 6; j++) begin
      ce.counter_value = 16'h0040 + 16'(j);
      cyc(1);
      check("chan trig", trig, 6'h2b & (6'h01 << j));
    end
    cyc(1);
    check("chan trig held", trig, 6'h00);
    ce.counter_initial_value = 16'h0007;
    ce.counter_value = 16'h0007;
    pte = 1'b1;
    for (j = 0; j < 5; j++) begin
      {ce.natural_wrap, ce.counter_write, ce.counter_sync, ce.clock_start,
       ce.capture_reset} = 5'h01 << j;
      cyc(1);
      {ce.natural_wrap, ce.counter_write, ce.counter_sync, ce.clock_start,
       ce.capture_reset} = 5'h00;
      check("init trig", itrig, 1'b1);
      cyc(1);
      check("init trig width", itrig, 1'b0);
    end
    // a clock start away from the initial value is no reload
    ce.counter_value = 16'h0008;
    ce.clock_start = 1'b1;
    cyc(1);
    ce.clock_start = 1'b0;
    check("start off initial", itrig, 1'b0);
    pte = 1'b0;
    ce.natural_wrap = 1'b1;
    cyc(1);
    ce.natural_wrap = 1'b0;
    check("init trig off", itrig, 1'b0);
    cyc(2);
    check("pulse count", trig_cnt - n0, 8'h09);
  endtask

  // hang guard, far beyond the 172 cycles of the run
  initial begin
    #50000;
    mismatches++;
    final_report();
  end

  initial begin
    {pwm, mwd, mwr, sync, cs, irqe, fp, pte, clr, ten, cmpv} = '0;
    fc = '0;
    cc = '0;
    ce = '0;
    pwm = 8'haa;
    cyc(12);
    rst_b_i = 1'b1;
    cyc(1);
    check("reset outputs", {out_mask, flags, trig}, 18'h0);
    t_mask();
    t_bypass();
    t_filter();
    t_recover(2'h1);
    t_recover(2'h2);
    t_recover(2'h3);
    t_preset();
    t_trig();
    final_report();
  end
endmodule
